// file: hw/pmc_regs.svh
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define PMC_OFS_CTRL 4'h0
`define PMC_OFS_STATUS 4'h4
`define PMC_OFS_CLKCFG 4'h8
`define PMC_OFS_PERIPH 4'hC

// ----------------------------------------------------------------
// Mode control register fields
// ----------------------------------------------------------------
`define PMC_CTRL_PSM 0
`define PMC_CTRL_IDLE 1
`define PMC_CTRL_HALT 2
`define PMC_CTRL_DEFER 3
`define PMC_CTRL_DMC 4
`define PMC_CTRL_DHC 5
`define PMC_CTRL_RST 6'h00

// ----------------------------------------------------------------
// Clock configuration register fields
// ----------------------------------------------------------------
`define PMC_CFG_FAST_MAIN 0
`define PMC_CFG_PLL_PWD 1
`define PMC_CFG_SLOW_LFO 2
`define PMC_CFG_HCC_EN 3
`define PMC_CFG_AUX1 4
`define PMC_CFG_AUX2 5
`define PMC_CFG_CONV 6
`define PMC_CFG_RST 7'h03

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define PMC_ST_LFO 0
`define PMC_ST_MAIN 1
`define PMC_ST_PLL 2
`define PMC_ST_HOLD 3
`define PMC_ST_MODE_LSB 4

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define PMC_PERIPH_RST 8'h00
`define PMC_SLOW_DIV 763

`endif

// file: hw/pmc_pkg.sv
package pmc_pkg;

	// Operating modes, one-hot; WAKE is the oscillator restart step
	typedef enum logic [4:0] {
		PMC_ST_ACTIVE = 5'h01,
		PMC_ST_SAVE = 5'h02,
		PMC_ST_IDLE = 5'h04,
		PMC_ST_HALT = 5'h08,
		PMC_ST_WAKE = 5'h10
	} pmc_mode_t;

	// System clock sources
	typedef enum logic [1:0] {
		PMC_SRC_MAIN = 2'h0,
		PMC_SRC_PLL = 2'h1,
		PMC_SRC_SLOW = 2'h2
	} pmc_src_t;

endpackage : pmc_pkg

// file: hw/pmc_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous level inputs
module pmc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end

endmodule : pmc_sync

// file: hw/pmc_clk_switch.sv
`timescale 1ns/1ns
// Break-before-make clock source selector and gate
module pmc_clk_switch
	import pmc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Requested source and gate
	input wire pmc_src_t req_src,
	input wire logic req_on,
	// Applied source and gate
	output pmc_src_t src_ff,
	output logic en_ff
);

	// Gate drops first, source moves a cycle later, gate reopens a cycle after that
	always_ff @(posedge mclk) begin
		if (srst) begin
			src_ff <= PMC_SRC_MAIN;
			en_ff <= 1'b1;
		end else if (en_ff && (!req_on || req_src != src_ff)) begin
			en_ff <= 1'b0;
		end else if (!en_ff && req_src != src_ff) begin
			src_ff <= req_src;
		end else if (!en_ff) begin
			en_ff <= req_on;
		end
	end

endmodule : pmc_clk_switch

// file: hw/pmc_ctrl.sv
// Summary of operation
// - Four modes: Active, Power Save, Idle, Halt, each with own clock setup.
// - Active runs main oscillator; timing/watchdog unit ticks from slow clock.
// - Active system clock comes from PLL or directly from main clock.
// - Power Save switches system clock to the slow clock.
// - In Power Save CPU and running modules keep working at slow rate.
// - Main oscillator may be disabled in Save/Idle only with slow clock from LFO; the code lets hardware clock control stop it with any slow source.
// - With hardware clock control on, it switches main oscillator and PLL.
// - Auxiliary clocks run in Save/Idle only while main clock runs.
// - Idle gates system clock; power manager and watchdog keep slow clock.
// - Halt stops all clocks, powers down oscillator and PLL, keeps state.
// - Timing counter and watchdog do not advance during Halt.
// - Low-frequency oscillator runs in every mode.
// - Wake-up detection stays live in Idle and Halt.
// - Halt leaves the converter enabled; only its clock stops.
// - In Active each peripheral follows its own enable bit.
// - After WAIT the CPU holds off new instructions until an interrupt.
// - Any reset starts the controller in Active mode.
// - Without deferral, writing the save request bit starts the switch to Power Save.
// - With deferral set, mode changes wait for the next WAIT instruction.
// - Halt wake-up restarts oscillator; halt bit clears once it is stable.
// - Active mode is never entered before oscillator and enabled PLL are stable; reset enters Active at once without waiting.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "pmc_regs.svh"
module pmc_ctrl
	import pmc_pkg::*;
#(
	parameter int SLOW_DIV = `PMC_SLOW_DIV,
	parameter int NPERIPH = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Oscillator status pins
	input wire logic main_osc_stable,
	input wire logic pll_stable,
	input wire logic lfo_stable,
	// CPU and wake-up monitor
	input wire logic wait_exec,
	input wire logic cpu_irq,
	input wire logic wakeup,
	// Hardware clock control requests
	input wire logic hcc_main_req,
	input wire logic hcc_pll_req,
	// Oscillator controls
	output logic main_osc_en,
	output logic pll_en,
	output logic lfo_en,
	// Clock distribution
	output logic sysclk_en,
	output pmc_src_t sysclk_src,
	output logic slow_tick,
	output logic twm_tick,
	output logic aux1_en,
	output logic aux2_en,
	output logic conv_clk_en,
	output logic [NPERIPH-1:0] periph_clk_en,
	// CPU control
	output logic cpu_hold
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam int DIVW = $clog2(SLOW_DIV + 1);

	pmc_mode_t mode_ff;
	pmc_mode_t nxt_mode;
	logic [5:0] ctrl_ff;
	logic [6:0] cfg_ff;
	logic [NPERIPH-1:0] periph_ff;
	logic [DIVW-1:0] div_ff;
	logic [2:0] osc_sync;
	logic main_ok, pll_ok, lfo_ok;
	logic acc_done, wr_ctrl, wr_cfg, wr_periph;
	logic low_mode, main_run, pll_run, pll_want;
	pmc_src_t req_src;
	logic req_on;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	pmc_sync #(
		.WIDTH(3)
	) u_sync (
		.mclk(mclk),
		.srst(srst),
		.async_in({lfo_stable, pll_stable, main_osc_stable}),
		.sync_out(osc_sync)
	);

	// PLL counts as ready when stable or powered down by its config bit
	assign main_ok = osc_sync[0];
	assign lfo_ok = osc_sync[2];
	assign pll_want = !cfg_ff[`PMC_CFG_PLL_PWD];
	assign pll_ok = osc_sync[1] || !pll_want;

	// ------------------------------------------------------------
	// Avalon-MM slave
	// ------------------------------------------------------------
	// One wait cycle, then the access completes
	always_ff @(posedge mclk) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
		end else if ((avs_read || avs_write) && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	assign acc_done = avs_write && !avs_waitrequest;
	assign wr_ctrl = acc_done && avs_address == `PMC_OFS_CTRL;
	assign wr_cfg = acc_done && avs_address == `PMC_OFS_CLKCFG;
	assign wr_periph = acc_done && avs_address == `PMC_OFS_PERIPH;

	// Read data loaded with the wait release; unmapped reads return zero
	always_ff @(posedge mclk) begin
		if (srst) begin
			avs_readdata <= 32'h0;
		end else if (avs_read && avs_waitrequest) begin
			unique case (avs_address)
				`PMC_OFS_CTRL: avs_readdata <= {26'h0, ctrl_ff};
				`PMC_OFS_STATUS: avs_readdata <= {23'h0, mode_ff, cpu_hold, osc_sync[1] || !pll_run,
					main_ok, lfo_ok};
				`PMC_OFS_CLKCFG: avs_readdata <= {25'h0, cfg_ff};
				`PMC_OFS_PERIPH: avs_readdata <= {{(32 - NPERIPH){1'b0}}, periph_ff};
				default: avs_readdata <= 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Mode request bits: software sets, wake-up and halt exit clear
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_ff <= `PMC_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_ff <= avs_writedata[5:0];
		end else if (wakeup && low_mode) begin
			ctrl_ff[`PMC_CTRL_PSM] <= 1'b0;
			ctrl_ff[`PMC_CTRL_IDLE] <= 1'b0;
			ctrl_ff[`PMC_CTRL_DMC] <= 1'b0;
			ctrl_ff[`PMC_CTRL_DHC] <= 1'b0;
		end else if (mode_ff == PMC_ST_WAKE && nxt_mode == PMC_ST_ACTIVE) begin
			ctrl_ff[`PMC_CTRL_HALT] <= 1'b0;
		end
	end

	// Clock configuration; PLL select and power-down interlock
	always_ff @(posedge mclk) begin
		if (srst) begin
			cfg_ff <= `PMC_CFG_RST;
		end else if (wr_cfg) begin
			cfg_ff[6:2] <= avs_writedata[6:2];
			if (avs_writedata[`PMC_CFG_FAST_MAIN] || (pll_want && osc_sync[1])) begin
				cfg_ff[`PMC_CFG_FAST_MAIN] <= avs_writedata[`PMC_CFG_FAST_MAIN];
			end
			if (!avs_writedata[`PMC_CFG_PLL_PWD] || cfg_ff[`PMC_CFG_FAST_MAIN]) begin
				cfg_ff[`PMC_CFG_PLL_PWD] <= avs_writedata[`PMC_CFG_PLL_PWD];
			end
		end
	end

	// Peripheral enables, untouched by mode changes
	always_ff @(posedge mclk) begin
		if (srst) begin
			periph_ff <= `PMC_PERIPH_RST;
		end else if (wr_periph) begin
			periph_ff <= avs_writedata[NPERIPH-1:0];
		end
	end

	// ------------------------------------------------------------
	// Mode state machine
	// ------------------------------------------------------------
	assign low_mode = mode_ff == PMC_ST_SAVE || mode_ff == PMC_ST_IDLE || mode_ff == PMC_ST_HALT;

	// Next mode selection
	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			PMC_ST_ACTIVE: begin
				if (lfo_ok && ctrl_ff[`PMC_CTRL_DEFER] && wait_exec) begin
					if (ctrl_ff[`PMC_CTRL_HALT]) begin
						nxt_mode = PMC_ST_HALT;
					end else if (ctrl_ff[`PMC_CTRL_IDLE]) begin
						nxt_mode = PMC_ST_IDLE;
					end else if (ctrl_ff[`PMC_CTRL_PSM]) begin
						nxt_mode = PMC_ST_SAVE;
					end
				end else if (lfo_ok && !ctrl_ff[`PMC_CTRL_DEFER] && ctrl_ff[`PMC_CTRL_PSM]) begin
					nxt_mode = PMC_ST_SAVE;
				end
			end
			PMC_ST_SAVE: begin
				if (wakeup || !ctrl_ff[`PMC_CTRL_PSM]) begin
					nxt_mode = PMC_ST_WAKE;
				end
			end
			PMC_ST_IDLE: begin
				if (wakeup || !ctrl_ff[`PMC_CTRL_IDLE]) begin
					nxt_mode = PMC_ST_WAKE;
				end
			end
			PMC_ST_HALT: begin
				if (wakeup) begin
					nxt_mode = PMC_ST_WAKE;
				end
			end
			PMC_ST_WAKE: begin
				if (main_ok && pll_ok) begin
					nxt_mode = PMC_ST_ACTIVE;
				end
			end
			default: nxt_mode = PMC_ST_WAKE;
		endcase
	end

	// Mode register; reset lands in Active
	always_ff @(posedge mclk) begin
		if (srst) begin
			mode_ff <= PMC_ST_ACTIVE;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// ------------------------------------------------------------
	// Oscillator and PLL control
	// ------------------------------------------------------------
	// Disable bits act only in Save/Idle; main disable needs the LFO slow source
	always_comb begin
		main_run = 1'b1;
		pll_run = pll_want;
		if (mode_ff == PMC_ST_HALT) begin
			main_run = 1'b0;
			pll_run = 1'b0;
		end else if (mode_ff == PMC_ST_SAVE || mode_ff == PMC_ST_IDLE) begin
			if (cfg_ff[`PMC_CFG_HCC_EN]) begin
				main_run = hcc_main_req;
				pll_run = pll_want && hcc_pll_req;
			end
			if (ctrl_ff[`PMC_CTRL_DMC] && cfg_ff[`PMC_CFG_SLOW_LFO]) begin
				main_run = 1'b0;
			end
			if (ctrl_ff[`PMC_CTRL_DHC] || !main_run) begin
				pll_run = 1'b0;
			end
		end
	end

	// Registered oscillator enables; LFO never stopped
	always_ff @(posedge mclk) begin
		if (srst) begin
			main_osc_en <= 1'b1;
			pll_en <= 1'b0;
			lfo_en <= 1'b1;
		end else begin
			main_osc_en <= main_run;
			pll_en <= pll_run;
			lfo_en <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// System clock selection and gating
	// ------------------------------------------------------------
	// Source per mode: fast in Active, slow in Save, off otherwise
	always_comb begin
		req_src = PMC_SRC_MAIN;
		req_on = 1'b0;
		unique case (mode_ff)
			PMC_ST_ACTIVE: begin
				req_on = 1'b1;
				if (!cfg_ff[`PMC_CFG_FAST_MAIN] && pll_want && osc_sync[1]) begin
					req_src = PMC_SRC_PLL;
				end
			end
			PMC_ST_SAVE: begin
				req_src = PMC_SRC_SLOW;
				req_on = 1'b1;
			end
			default: req_on = 1'b0;
		endcase
	end

	pmc_clk_switch u_sysclk (
		.mclk(mclk),
		.srst(srst),
		.req_src(req_src),
		.req_on(req_on),
		.src_ff(sysclk_src),
		.en_ff(sysclk_en)
	);

	// ------------------------------------------------------------
	// Slow clock divider and watchdog tick
	// ------------------------------------------------------------
	// Divider frozen in Halt so timing and watchdog stand still
	always_ff @(posedge mclk) begin
		if (srst) begin
			div_ff <= '0;
			slow_tick <= 1'b0;
			twm_tick <= 1'b0;
		end else if (mode_ff == PMC_ST_HALT) begin
			slow_tick <= 1'b0;
			twm_tick <= 1'b0;
		end else if (div_ff == DIVW'(SLOW_DIV - 1)) begin
			div_ff <= '0;
			slow_tick <= 1'b1;
			twm_tick <= 1'b1;
		end else begin
			div_ff <= div_ff + 1'b1;
			slow_tick <= 1'b0;
			twm_tick <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Auxiliary, converter and peripheral clocks
	// ------------------------------------------------------------
	// Aux clocks need a stable running main clock; converter enable survives Halt
	always_ff @(posedge mclk) begin
		if (srst) begin
			aux1_en <= 1'b0;
			aux2_en <= 1'b0;
			conv_clk_en <= 1'b0;
			periph_clk_en <= '0;
		end else begin
			aux1_en <= cfg_ff[`PMC_CFG_AUX1] && main_run && main_ok;
			aux2_en <= cfg_ff[`PMC_CFG_AUX2] && main_run && main_ok;
			conv_clk_en <= cfg_ff[`PMC_CFG_CONV] && cfg_ff[`PMC_CFG_AUX2] && main_run
				&& main_ok;
			if (mode_ff == PMC_ST_ACTIVE || mode_ff == PMC_ST_SAVE) begin
				periph_clk_en <= periph_ff;
			end else begin
				periph_clk_en <= '0;
			end
		end
	end

	// ------------------------------------------------------------
	// CPU hold after WAIT
	// ------------------------------------------------------------
	// Interrupt or wake-up releases; a new WAIT in the same cycle loses
	always_ff @(posedge mclk) begin
		if (srst) begin
			cpu_hold <= 1'b0;
		end else if (cpu_irq || wakeup) begin
			cpu_hold <= 1'b0;
		end else if (wait_exec) begin
			cpu_hold <= 1'b1;
		end
	end

endmodule : pmc_ctrl

// file: tb/pmc_ctrl_assertions.sv
`timescale 1ns/1ns
// ------
// Power mode checker
// ------
module pmc_ctrl_chk
	import pmc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic srst,
	// Bus handshake
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	// Clock controls
	input wire logic main_osc_en,
	input wire logic lfo_en,
	input wire logic sysclk_en,
	input wire pmc_src_t sysclk_src,
	input wire logic slow_tick,
	input wire logic twm_tick,
	input wire logic aux1_en,
	input wire logic aux2_en,
	// CPU side
	input wire logic wait_exec,
	input wire logic cpu_irq,
	input wire logic wakeup,
	input wire logic cpu_hold
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// Reset leaves Active mode with its clocks running
	reset_state_a: assert property ($fell(srst) |-> main_osc_en && sysclk_en && !cpu_hold)
		else $error("state after reset is not Active");
	low_osc_run_a: assert property (lfo_en)
		else $error("low oscillator stopped");
	twm_tick_a: assert property (twm_tick == slow_tick)
		else $error("watchdog tick differs from slow tick");
	tick_pulse_a: assert property (slow_tick |=> !slow_tick)
		else $error("slow tick longer than one cycle");
	// Source may only move while the gate has been closed a full cycle
	src_gated_a: assert property ($changed(sysclk_src) |-> !sysclk_en && $past(!sysclk_en))
		else $error("clock source changed while gate open");
	hold_set_a: assert property (wait_exec && !cpu_irq && !wakeup |=> cpu_hold)
		else $error("no hold after wait");
	hold_clear_a: assert property (cpu_irq || wakeup |=> !cpu_hold)
		else $error("hold not cleared by interrupt");
	aux_main_a: assert property (!main_osc_en [*2] |-> !aux1_en && !aux2_en)
		else $error("aux clock without main clock");
	bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
endmodule : pmc_ctrl_chk

bind pmc_ctrl pmc_ctrl_chk u_chk (.mclk(mclk), .srst(srst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .main_osc_en(main_osc_en),
	.lfo_en(lfo_en), .sysclk_en(sysclk_en), .sysclk_src(sysclk_src), .slow_tick(slow_tick),
	.twm_tick(twm_tick), .aux1_en(aux1_en), .aux2_en(aux2_en), .wait_exec(wait_exec),
	.cpu_irq(cpu_irq), .wakeup(wakeup), .cpu_hold(cpu_hold));

// file: tb/pmc_osc_model.sv
`timescale 1ns/1ns
// ------
// Oscillator partner: stable only after a start-up delay
// ------
module pmc_osc_model #(
	parameter int DLY = 20
) (
	// Clock
	input wire logic mclk,
	// Enables from the controller
	input wire logic main_osc_en,
	input wire logic pll_en,
	// Stability pins
	output logic main_osc_stable,
	output logic pll_stable,
	output logic lfo_stable
);
	int mcnt = 0;
	int pcnt = 0;
	initial main_osc_stable = 1'b0;
	initial pll_stable = 1'b0;
	assign lfo_stable = 1'b1;
	// Start-up counters; a stopped oscillator turns unstable one cycle after its enable is seen low
	always @(posedge mclk) begin
		mcnt <= main_osc_en === 1'b1 ? (mcnt < DLY ? mcnt + 1 : mcnt) : 0;
		pcnt <= pll_en === 1'b1 ? (pcnt < DLY ? pcnt + 1 : pcnt) : 0;
		main_osc_stable <= mcnt >= DLY;
		pll_stable <= pcnt >= DLY;
	end
endmodule : pmc_osc_model

// file: tb/tb_top.sv
`timescale 1ns/1ns
`include "pmc_regs.svh"
module tb_top
	import pmc_pkg::*;
;
	logic mclk, srst, avs_read, avs_write, wait_exec, cpu_irq, wakeup, hcc_main_req, hcc_pll_req;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rnd;
	logic avs_waitrequest, main_osc_stable, pll_stable, lfo_stable, main_osc_en, pll_en, lfo_en;
	logic sysclk_en, slow_tick, twm_tick, aux1_en, aux2_en, conv_clk_en, cpu_hold;
	logic [7:0] periph_clk_en;
	pmc_src_t sysclk_src;
	logic [31:0] expq[$];
	int fail_count, compares, cyc, ticks, t0;
	// ------
	// Design, oscillators and clock
	// ------
	pmc_ctrl #(.SLOW_DIV(4), .NPERIPH(8)) dut (.mclk(mclk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .main_osc_stable(main_osc_stable),
		.pll_stable(pll_stable), .lfo_stable(lfo_stable), .wait_exec(wait_exec),
		.cpu_irq(cpu_irq), .wakeup(wakeup), .hcc_main_req(hcc_main_req),
		.hcc_pll_req(hcc_pll_req), .main_osc_en(main_osc_en), .pll_en(pll_en),
		.lfo_en(lfo_en), .sysclk_en(sysclk_en), .sysclk_src(sysclk_src),
		.slow_tick(slow_tick), .twm_tick(twm_tick), .aux1_en(aux1_en), .aux2_en(aux2_en),
		.conv_clk_en(conv_clk_en), .periph_clk_en(periph_clk_en), .cpu_hold(cpu_hold));
	pmc_osc_model #(.DLY(20)) osc (.mclk(mclk), .main_osc_en(main_osc_en), .pll_en(pll_en),
		.main_osc_stable(main_osc_stable), .pll_stable(pll_stable), .lfo_stable(lfo_stable));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// ------
	// Helpers
	// ------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic end_of_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// One bus word; a read notes its expected data for the monitor
	task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d,
		input logic [31:0] e);
		@(posedge mclk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= d;
		if (!wr)
			expq.push_back(e);
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	// One-cycle pulse: 0 wake-up, 1 wait executed, 2 interrupt; returns one cycle after the pulse ends
	task automatic pl(input int w);
		@(posedge mclk);
		wakeup <= w == 0;
		wait_exec <= w == 1;
		cpu_irq <= w == 2;
		@(posedge mclk);
		wakeup <= 1'b0;
		wait_exec <= 1'b0;
		cpu_irq <= 1'b0;
		@(posedge mclk);
	endtask : pl
	// Slow ticks seen over 40 cycles, counted between falling edges
	task automatic tk(input logic [31:0] e);
		@(negedge mclk);
		t0 = ticks;
		repeat (40) @(negedge mclk);
		chk("ticks", ticks - t0, e);
	endtask : tk
	// Read monitor, tick counter and timeout
	always @(posedge mclk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			chk("readdata", avs_readdata, expq.size() > 0 ? expq.pop_front() : 32'hDEAD);
		if (slow_tick === 1'b1)
			ticks++;
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			end_of_test();
		end
	end
	// ------
	// Main sequence
	// ------
	initial begin
		{srst, avs_read, avs_write, wait_exec, cpu_irq, wakeup} = 6'h20;
		{hcc_main_req, hcc_pll_req, avs_address, avs_writedata} = '0;
		rnd = 32'h92D5;
		repeat (12) @(posedge mclk);
		srst <= 1'b0;
		repeat (30) @(posedge mclk);
		bus(`PMC_OFS_CTRL, 0, 0, 32'h00);
		bus(`PMC_OFS_CLKCFG, 0, 0, 32'h03);
		bus(`PMC_OFS_STATUS, 0, 0, 32'h17);
		bus(4'h2, 0, 0, 32'h00);
		for (int i = 0; i < 3; i++) begin
			rnd = xs(rnd);
			bus(`PMC_OFS_PERIPH, 1, rnd, 0);
			bus(`PMC_OFS_PERIPH, 0, 0, {24'h0, rnd[7:0]});
			chk("periph", 32'(periph_clk_en), {24'h0, rnd[7:0]});
		end
		tk(32'hA);
		bus(`PMC_OFS_CLKCFG, 1, 32'h73, 0);
		repeat (4) @(posedge mclk);
		chk("aux1", 32'(aux1_en), 32'h1);
		chk("aux2", 32'(aux2_en), 32'h1);
		chk("conv", 32'(conv_clk_en), 32'h1);
		pl(1);
		chk("hold", 32'(cpu_hold), 32'h1);
		pl(2);
		chk("hold", 32'(cpu_hold), 32'h0);
		bus(`PMC_OFS_CTRL, 1, 32'h01, 0);
		repeat (6) @(posedge mclk);
		chk("src", 32'(sysclk_src), 32'(PMC_SRC_SLOW));
		chk("sysclk", 32'(sysclk_en), 32'h1);
		bus(`PMC_OFS_STATUS, 0, 0, 32'h27);
		pl(0);
		repeat (10) @(posedge mclk);
		chk("src", 32'(sysclk_src), 32'(PMC_SRC_MAIN));
		bus(`PMC_OFS_CTRL, 1, 32'h0A, 0);
		pl(1);
		repeat (6) @(posedge mclk);
		chk("sysclk", 32'(sysclk_en), 32'h0);
		chk("periph", 32'(periph_clk_en), 32'h0);
		tk(32'hA);
		pl(0);
		repeat (10) @(posedge mclk);
		bus(`PMC_OFS_CTRL, 1, 32'h0C, 0);
		bus(`PMC_OFS_STATUS, 0, 0, 32'h17);
		pl(1);
		repeat (6) @(posedge mclk);
		chk("osc", 32'({main_osc_en, pll_en, sysclk_en, aux1_en}), 32'h0);
		chk("conv", 32'(conv_clk_en), 32'h0);
		tk(32'h0);
		bus(`PMC_OFS_CLKCFG, 0, 0, 32'h73);
		pl(0);
		bus(`PMC_OFS_STATUS, 0, 0, 32'h105);
		repeat (40) @(posedge mclk);
		chk("sysclk", 32'(sysclk_en), 32'h1);
		bus(`PMC_OFS_CTRL, 0, 0, 32'h08);
		bus(`PMC_OFS_STATUS, 0, 0, 32'h17);
		// Hardware clock control and main disable in Power Save
		bus(`PMC_OFS_CLKCFG, 1, 32'h1F, 0);
		bus(`PMC_OFS_CTRL, 1, 32'h01, 0);
		repeat (6) @(posedge mclk);
		chk("hcc", 32'({main_osc_en, aux1_en}), 32'h0);
		hcc_main_req <= 1'b1;
		repeat (40) @(posedge mclk);
		chk("hcc", 32'({main_osc_en, aux1_en}), 32'h3);
		bus(`PMC_OFS_CTRL, 1, 32'h11, 0);
		repeat (4) @(posedge mclk);
		chk("dmc", 32'({main_osc_en, aux1_en}), 32'h0);
		pl(0);
		repeat (40) @(posedge mclk);
		bus(`PMC_OFS_STATUS, 0, 0, 32'h17);
		bus(`PMC_OFS_CTRL, 0, 0, 32'h00);
		repeat (4) @(posedge mclk);
		end_of_test();
	end
endmodule : tb_top
